// [core/cdhp_pkg.sv]
package cdhp_pkg;
   localparam int          CDHP_LINE_CHARS    = 8;
   localparam int          CDHP_TEXT_DEPTH    = 80;
   localparam logic [6:0]  CDHP_LINE1_BASE    = 7'h00;
   localparam logic [6:0]  CDHP_LINE2_BASE    = 7'h40;
   localparam logic [6:0]  CDHP_LINE1_LAST    = 7'h27;
   localparam logic [6:0]  CDHP_LINE2_LAST    = 7'h67;
   localparam int          CDHP_GLYPH_BYTES   = 64;
   localparam int          CDHP_ROM_SMALL     = 192;
   localparam int          CDHP_ROM_TALL      = 32;
   localparam logic [7:0]  CDHP_SPACE_CODE    = 8'h20;
   localparam logic [7:0]  CDHP_RESET_FUNC    = 8'h30;
   localparam int          CDHP_CLK_MHZ       = 50;
   localparam int          CDHP_CMD_TIME_NS   = 38000;
   localparam int          CDHP_CMD_CYCLES    = (CDHP_CMD_TIME_NS * CDHP_CLK_MHZ + 999) / 1000;
   localparam int          CDHP_CLR_TIME_NS   = 1520000;
   localparam int          CDHP_CLR_CYCLES    = (CDHP_CLR_TIME_NS * CDHP_CLK_MHZ + 999) / 1000;
   localparam int          CDHP_SYNC_STAGES   = 2;
   typedef enum logic [1:0] {cdhp_idle, cdhp_busy, cdhp_clear} cdhp_state_t;
endpackage

// [core/cdhp_sync.sv]
module cdhp_sync
   import cdhp_pkg::*;
#(
   parameter int W = 1
)(
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   always_comb
   begin
      next_meta = ce ? d : meta;
      next_q    = ce ? meta : q;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         meta <= '0;
         q    <= '0;
      end
      else
      begin
         meta <= next_meta;
         q    <= next_q;
      end
   end
endmodule

// [core/cdhp_top.sv]
// Behaviour
// - register_select high reaches data register, low reaches instruction register.
// - host bus is 4-bit or 8-bit, chosen by bit 4 of the function set command.
// - display shows two lines of eight character positions.
// - line one positions 1..8 read text memory 00h..07h in order.
// - line two positions 1..8 read text memory 40h..47h in order.
// - text memory stores 80 eight-bit character codes.
// - user glyph memory holds 64 bytes, eight 5x8 glyphs.
// - fixed glyph ROM sizes of 192 5x7 glyphs and 32 5x10 glyphs stand as constants only; no glyph ROM is built.
// - instruction read returns busy_indicator on bit 7, address_counter below.
// - in 4-bit mode each byte moves as two nibble transfers.
module cdhp_top
   import cdhp_pkg::*;
#(
   parameter int CMD_CYCLES = CDHP_CMD_CYCLES,
   parameter int CLR_CYCLES = CDHP_CLR_CYCLES
)(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       register_select,
   input  wire logic       read_not_write,
   input  wire logic       enable,
   input  wire logic [7:0] db_in,
   output logic      [7:0] db_out,
   output logic            db_oe,
   output logic            busy_indicator,
   output logic      [6:0] address_counter,
   output logic      [3:0] scan_pos,
   output logic      [7:0] scan_code
);
   logic [10:0] pins;
   logic        rs_s;
   logic        rw_s;
   logic        en_s;
   logic [7:0]  db_s;
   logic        en_d;
   assign {rs_s, rw_s, en_s, db_s} = pins;

   cdhp_sync #(.W(11)) u_sync (
      .mclk (mclk),
      .rst  (rst),
      .ce   (ce),
      .d    ({register_select, read_not_write, enable, db_in}),
      .q    (pins)
   );

   // Storage
   logic [7:0] text_mem [CDHP_TEXT_DEPTH];
   logic [7:0] glyph_mem [CDHP_GLYPH_BYTES];
   // Control state
   cdhp_state_t state, next_state;
   logic [20:0] timer, next_timer;
   logic [6:0]  ac, next_ac;
   logic        to_glyph, next_to_glyph;
   logic        bus8, next_bus8;
   logic        incr, next_incr;
   logic        half, next_half;
   logic [3:0]  hi_nib, next_hi_nib;
   logic [6:0]  clr_idx, next_clr_idx;
   logic [7:0]  next_db_out;
   logic        next_db_oe;
   logic [3:0]  next_scan_pos;
   logic [7:0]  next_scan_code;
   logic        strobe_fall;
   logic        byte_done;
   logic [7:0]  byte_in;
   logic        wr_text;
   logic        wr_glyph;
   logic [6:0]  text_idx;
   logic [6:0]  ac_step;
   logic [6:0]  scan_addr;

   assign strobe_fall = en_d && !en_s;

   function automatic logic [6:0] cdhp_index(input logic [6:0] a);
      cdhp_index = a[6] ? 7'({1'b0, a[5:0]} + 7'h28) : a;
   endfunction

   function automatic logic [6:0] cdhp_step(input logic [6:0] a, input logic up);
      if (up)
         cdhp_step = (a == CDHP_LINE1_LAST) ? CDHP_LINE2_BASE :
                     (a == CDHP_LINE2_LAST) ? CDHP_LINE1_BASE : 7'(a + 7'h01);
      else
         cdhp_step = (a == CDHP_LINE2_BASE) ? CDHP_LINE1_LAST :
                     (a == CDHP_LINE1_BASE) ? CDHP_LINE2_LAST : 7'(a - 7'h01);
   endfunction

   always_comb
   begin
      next_state    = state;
      next_timer    = timer;
      next_ac       = ac;
      next_to_glyph = to_glyph;
      next_bus8     = bus8;
      next_incr     = incr;
      next_half     = half;
      next_hi_nib   = hi_nib;
      next_clr_idx  = clr_idx;
      next_db_oe    = rw_s && en_s;
      next_db_out   = db_out;
      byte_done     = 1'b0;
      byte_in       = db_s;
      wr_text       = 1'b0;
      wr_glyph      = 1'b0;
      text_idx      = cdhp_index(ac);
      ac_step       = cdhp_step(ac, incr);
      if (strobe_fall)
      begin
         if (bus8)
            byte_done = 1'b1;
         else if (!half)
         begin
            next_half   = 1'b1;
            next_hi_nib = db_s[7:4];
         end
         else
         begin
            next_half = 1'b0;
            byte_done = 1'b1;
            byte_in   = {hi_nib, db_s[7:4]};
         end
      end
      // read path, bus flag over counter
      if (rw_s)
      begin
         if (!rs_s)
            next_db_out = {state != cdhp_idle, ac};
         else
            next_db_out = to_glyph ? glyph_mem[ac[5:0]] : text_mem[text_idx];
         if (!bus8 && half)
            next_db_out = {next_db_out[3:0], 4'h0};
      end
      unique case (state)
         cdhp_idle:
         begin
            if (byte_done && !rw_s)
            begin
               next_state = cdhp_busy;
               next_timer = 21'(CMD_CYCLES - 1);
               if (rs_s)
               begin
                  wr_glyph = to_glyph;
                  wr_text  = !to_glyph;
                  next_ac  = to_glyph ? {1'b0, 6'(ac[5:0] + 6'h01)} : ac_step;
               end
               else if (byte_in[7])
               begin
                  next_to_glyph = 1'b0;
                  next_ac       = byte_in[6:0];
               end
               else if (byte_in[6])
               begin
                  next_to_glyph = 1'b1;
                  next_ac       = {1'b0, byte_in[5:0]};
               end
               else if (byte_in[5])
                  next_bus8 = byte_in[4];
               else if (byte_in[4])
                  next_ac = byte_in[3] ? ac : cdhp_step(ac, byte_in[2]);
               else if (byte_in[3])
                  next_incr = incr;
               else if (byte_in[2])
                  next_incr = byte_in[1];
               else if (byte_in[1])
               begin
                  next_ac       = CDHP_LINE1_BASE;
                  next_to_glyph = 1'b0;
                  next_timer    = 21'(CLR_CYCLES - 1);
               end
               else if (byte_in[0])
               begin
                  next_state    = cdhp_clear;
                  next_clr_idx  = '0;
                  next_ac       = CDHP_LINE1_BASE;
                  next_incr     = 1'b1;
                  next_to_glyph = 1'b0;
                  next_timer    = 21'(CLR_CYCLES - 1);
               end
            end
            else if (byte_done && rs_s)
               next_ac = to_glyph ? {1'b0, 6'(ac[5:0] + 6'h01)} : ac_step;
         end
         cdhp_busy:
         begin
            if (timer == '0)
               next_state = cdhp_idle;
            else
               next_timer = 21'(timer - 21'd1);
         end
         cdhp_clear:
         begin
            wr_text  = 1'b1;
            text_idx = clr_idx;
            byte_in  = CDHP_SPACE_CODE;
            if (clr_idx != 7'(CDHP_TEXT_DEPTH - 1))
               next_clr_idx = 7'(clr_idx + 7'h01);
            if (timer == '0 && clr_idx == 7'(CDHP_TEXT_DEPTH - 1))
               next_state = cdhp_idle;
            else if (timer != '0)
               next_timer = 21'(timer - 21'd1);
         end
      endcase
   end

   // scan eight positions of two lines
   always_comb
   begin
      next_scan_pos = 4'(scan_pos + 4'h1);
      scan_addr     = (scan_pos[3] ? CDHP_LINE2_BASE : CDHP_LINE1_BASE) + {4'h0, scan_pos[2:0]};
      next_scan_code = text_mem[cdhp_index(scan_addr)];
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state           <= cdhp_idle;
         timer           <= '0;
         ac              <= '0;
         to_glyph        <= 1'b0;
         bus8            <= 1'b1;
         incr            <= 1'b1;
         half            <= 1'b0;
         hi_nib          <= '0;
         clr_idx         <= '0;
         en_d            <= 1'b0;
         db_out          <= '0;
         db_oe           <= 1'b0;
         scan_pos        <= '0;
         scan_code       <= '0;
         busy_indicator  <= 1'b0;
         address_counter <= '0;
      end
      else if (ce)
      begin
         state           <= next_state;
         timer           <= next_timer;
         ac              <= next_ac;
         to_glyph        <= next_to_glyph;
         bus8            <= next_bus8;
         incr            <= next_incr;
         half            <= next_half;
         hi_nib          <= next_hi_nib;
         clr_idx         <= next_clr_idx;
         en_d            <= en_s;
         db_out          <= next_db_out;
         db_oe           <= next_db_oe;
         scan_pos        <= next_scan_pos;
         // line positions map to 00h/40h upward
         scan_code       <= next_scan_code;
         busy_indicator  <= next_state != cdhp_idle;
         address_counter <= next_ac;
         if (wr_glyph)
            glyph_mem[ac[5:0]] <= byte_in;
         if (wr_text)
            text_mem[text_idx] <= byte_in;
      end
   end

   localparam int ROM_TOTAL = CDHP_ROM_SMALL + CDHP_ROM_TALL + 8 * 4;

   a_busy_flag: assert property (@(posedge mclk) disable iff (rst)
      ce |=> busy_indicator == (state != cdhp_idle))
      else $error("busy flag mismatch");
   a_line_two: assert property (@(posedge mclk) disable iff (rst)
      (ce && scan_pos == 4'h8) |-> scan_addr == CDHP_LINE2_BASE)
      else $error("line two base wrong");
   a_bus_drive: assert property (@(posedge mclk) disable iff (rst)
      db_oe |-> $past(rw_s))
      else $error("bus driven on write");
   a_status_read: assert property (@(posedge mclk) disable iff (rst)
      (ce && rw_s && !rs_s && (bus8 || !half))
         |=> db_out == {$past(busy_indicator), $past(address_counter)})
      else $error("status read wrong");
   a_write_busy: assert property (@(posedge mclk) disable iff (rst)
      (ce && byte_done && !rw_s && state == cdhp_idle) |=> busy_indicator)
      else $error("write did not start");
   a_nibble_pair: assert property (@(posedge mclk) disable iff (rst)
      (ce && !bus8 && strobe_fall) |=> half != $past(half))
      else $error("nibble pairing broken");
   c_cmd_write: cover property (@(posedge mclk) state == cdhp_busy);
   c_clear:     cover property (@(posedge mclk) state == cdhp_clear);
   c_nibble:    cover property (@(posedge mclk) !bus8 && half);
endmodule

// [sim/cdhp_host.sv]
module cdhp_host (
   input  wire logic       mclk,
   output logic            register_select,
   output logic            read_not_write,
   output logic            enable,
   output logic      [7:0] db_in,
   input  wire logic [7:0] db_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic nib4;
   initial
   begin
      register_select = 1'b0;
      read_not_write = 1'b0;
      enable = 1'b0;
      db_in = 8'h00;
      nib4 = 1'b0;
   end
   task automatic strobe(input logic rs, input logic rw, input logic [7:0] d,
                         output logic [7:0] q);
      @(posedge mclk);
      #1;
      register_select = rs;
      read_not_write = rw;
      // Released bus shows a changing pattern
      db_in = rw ? ~db_in : d;
      enable = 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      q = db_out;
      enable = 1'b0;
      repeat (5) @(posedge mclk);
   endtask
   // byte as one or two nibbles
   task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                       output logic [7:0] q);
      logic [7:0] h;
      logic [7:0] l;
      if (nib4)
      begin
         strobe(rs, rw, {d[7:4], 4'hA}, h);
         strobe(rs, rw, {d[3:0], 4'h5}, l);
         q = {h[7:4], l[7:4]};
      end
      else
         strobe(rs, rw, d, q);
   endtask
endmodule

// [sim/char_display_host_port_tb.sv]
module char_display_host_port_tb
   import cdhp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic       mclk;
   logic       rst;
   logic       ce;
   logic       register_select;
   logic       read_not_write;
   logic       enable;
   logic [7:0] db_in;
   logic [7:0] db_out;
   logic       db_oe;
   logic       busy_indicator;
   logic [6:0] address_counter;
   logic [3:0] scan_pos;
   logic [7:0] scan_code;
   int         err_count;
   int         checked;
   int         tm [128];
   int         mac;
   bit         dn;
   bit         gl;
   int         gm [64];
   logic [7:0] q;
   cdhp_top #(.CMD_CYCLES(40), .CLR_CYCLES(20)) u_cdhp_top (.mclk(mclk), .rst(rst), .ce(ce),
      .register_select(register_select), .read_not_write(read_not_write), .enable(enable),
      .db_in(db_in), .db_out(db_out), .db_oe(db_oe), .busy_indicator(busy_indicator),
      .address_counter(address_counter), .scan_pos(scan_pos), .scan_code(scan_code));
   cdhp_host host (.mclk(mclk), .register_select(register_select),
      .read_not_write(read_not_write), .enable(enable), .db_in(db_in), .db_out(db_out));
   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   task automatic results();
      $display("errors %0d checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Model of the address counter step
   function automatic int step_ac(input int a);
      if (gl)
         return (a + 1) % CDHP_GLYPH_BYTES;
      if (dn)
         return (a == CDHP_LINE2_BASE) ? CDHP_LINE1_LAST :
                (a == CDHP_LINE1_BASE) ? CDHP_LINE2_LAST : a - 1;
      return (a == CDHP_LINE1_LAST) ? CDHP_LINE2_BASE :
             (a == CDHP_LINE2_LAST) ? CDHP_LINE1_BASE : a + 1;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_ready(output logic [7:0] r);
      for (int i = 0; i < 100; i++)
      begin
         host.xfer(1'b0, 1'b1, 8'h00, r);
         if (r[7] === 1'b0)
            return;
      end
      err_count++;
      results();
   endtask
   task automatic cmd(input logic [7:0] c);
      host.xfer(1'b0, 1'b0, c, q);
      if (c == 8'h01)
      begin
         foreach (tm[i])
            tm[i] = 32;
         dn = 1'b0;
      end
      if (c[7:2] == 6'h00 && c[1:0] != 2'h0)
      begin
         mac = 0;
         gl = 1'b0;
      end
      if (c[7])
      begin
         mac = c[6:0];
         gl = 1'b0;
      end
      else if (c[6])
      begin
         mac = c[5:0];
         gl = 1'b1;
      end
      if (c[7:2] == 6'h01)
         dn = ~c[1];
      if (c[7:5] == 3'b001)
         host.nib4 = ~c[4];
      wait_ready(q);
      chk(q, 8'(mac));
   endtask
   task automatic wr(input logic [7:0] d);
      host.xfer(1'b1, 1'b0, d, q);
      if (gl)
         gm[mac] = d;
      else
         tm[mac] = d;
      mac = step_ac(mac);
      chk({7'h00, busy_indicator}, 8'h01);
      wait_ready(q);
      chk(q, 8'(mac));
      chk({1'b0, address_counter}, 8'(mac));
   endtask
   task automatic rdd();
      host.xfer(1'b1, 1'b1, 8'h00, q);
      chk(q, 8'(gl ? gm[mac] : tm[mac]));
      mac = step_ac(mac);
      wait_ready(q);
      chk(q, 8'(mac));
   endtask
   task automatic scan();
      int p;
      @(posedge mclk);
      #1;
      p = scan_pos;
      repeat (40)
      begin
         @(posedge mclk);
         #1;
         chk(scan_code, 8'(tm[p < 8 ? p : p + 56]));
         p = scan_pos;
      end
   endtask
   initial
   begin
      #1ms;
      err_count++;
      results();
   end
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      err_count = 0;
      checked = 0;
      mac = 0;
      void'($urandom(32'hE5305B5A));
      repeat (3) @(posedge mclk);
      #1;
      rst = 1'b0;
      wait_ready(q);
      chk(q, 8'h00);
      cmd(8'h01);
      scan();
      for (int m = 0; m < 2; m++)
      begin
         if (m == 1)
            cmd(8'h20);
         for (int b = 0; b < 2; b++)
         begin
            cmd(b ? 8'hC0 : 8'h80);
            repeat (8) wr(8'($urandom));
            cmd(b ? 8'hC0 : 8'h80);
            repeat (8) rdd();
         end
         scan();
      end
      cmd(8'hE7);
      wr(8'($urandom));
      cmd(8'hE7);
      rdd();
      // Low clock enable holds a running command
      host.xfer(1'b1, 1'b0, 8'hA5, q);
      tm[mac] = 8'hA5;
      mac = step_ac(mac);
      #1;
      ce = 1'b0;
      repeat (60) @(posedge mclk);
      #1;
      chk({7'h00, busy_indicator}, 8'h01);
      ce = 1'b1;
      wait_ready(q);
      chk(q, 8'(mac));
      // User glyph round trip
      cmd(8'h48);
      repeat (4) wr(8'($urandom));
      cmd(8'h48);
      repeat (4) rdd();
      // Decrement entry, display control, return home
      cmd(8'h04);
      cmd(8'h86);
      repeat (3) wr(8'($urandom));
      cmd(8'h06);
      cmd(8'h0C);
      cmd(8'h84);
      repeat (3) rdd();
      cmd(8'h02);
      // Second reset returns to 8-bit defaults
      #1;
      rst = 1'b1;
      host.nib4 = 1'b0;
      mac = 0;
      gl = 1'b0;
      dn = 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      rst = 1'b0;
      wait_ready(q);
      chk(q, 8'h00);
      cmd(8'h81);
      wr(8'($urandom));
      scan();
      results();
   end
endmodule
